// *** design/fcrc_pkg.sv ***
/*
 * Shared constants and types of the fast clock request controller.
 * Assumes a 20 MHz control clock and word-wide AHB-Lite register access.
 */
package fcrc_pkg;

  // ==========================================================
  // Clock plan, values in kHz, audio values in Hz
  localparam int unsigned CLK_KHZ        = 20000;
  localparam int unsigned APP_CPU_KHZ    = 128000;
  localparam int unsigned NET_CPU_KHZ    = 64000;
  localparam int unsigned FLASH_IF_KHZ   = 192000;
  localparam int unsigned USB_KHZ        = 48000;
  localparam int unsigned PERIPH_MID_KHZ = 32000;
  localparam int unsigned PERIPH_SLO_KHZ = 16000;
  localparam int unsigned CRYSTAL_KHZ    = 32000;
  localparam int unsigned AUDIO_LO_HZ    = 11289000;
  localparam int unsigned AUDIO_HI_HZ    = 12288000;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFS_MAIN_START  = 12'h000;
  localparam logic [11:0] OFS_MAIN_STOP   = 12'h004;
  localparam logic [11:0] OFS_QSPI_START  = 12'h008;
  localparam logic [11:0] OFS_QSPI_STOP   = 12'h00C;
  localparam logic [11:0] OFS_AUDIO_START = 12'h010;
  localparam logic [11:0] OFS_AUDIO_STOP  = 12'h014;
  localparam logic [11:0] OFS_EV_MAIN     = 12'h100;
  localparam logic [11:0] OFS_EV_QSPI     = 12'h104;
  localparam logic [11:0] OFS_EV_AUDIO    = 12'h108;
  localparam logic [11:0] OFS_IRQ_EN      = 12'h300;
  localparam logic [11:0] OFS_IRQ_EN_SET  = 12'h304;
  localparam logic [11:0] OFS_IRQ_EN_CLR  = 12'h308;
  localparam logic [11:0] OFS_STATUS      = 12'h400;
  localparam logic [11:0] OFS_MAIN_SRC    = 12'h500;
  localparam logic [11:0] OFS_MAIN_ALW    = 12'h504;
  localparam logic [11:0] OFS_QSPI_SRC    = 12'h508;
  localparam logic [11:0] OFS_QSPI_ALW    = 12'h50C;
  localparam logic [11:0] OFS_AUDIO_ALW   = 12'h510;
  localparam logic [11:0] OFS_XO_CNT      = 12'h520;

  // Status field positions
  localparam int unsigned STAT_RUN_POS  = 0;
  localparam int unsigned STAT_SRC_POS  = 4;
  localparam int unsigned STAT_EXPL_POS = 8;

  // Source codes and reset values
  localparam logic        SRC_INT     = 1'b0;
  localparam logic        SRC_XO      = 1'b1;
  localparam logic [15:0] XO_CNT_RST  = 16'h0040;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CH_IDLE   = 2'b00,
    CH_WAIT   = 2'b01,
    CH_RUN    = 2'b11,
    CH_SWITCH = 2'b10
  } fcrc_ch_e;

  typedef struct packed {
    fcrc_ch_e    st;
    logic        expl;
    logic        pend;
    logic        alw;
    logic        sel;
    logic        act;
    logic [15:0] cnt;
    logic        evt;
  } fcrc_ch_s;

  typedef struct packed {
    logic main;
    logic qspi;
    logic audio;
  } fcrc_tri_s;

  typedef struct packed {
    fcrc_tri_s req;
    fcrc_tri_s expl;
    fcrc_tri_s src;
  } fcrc_sub_s;

  typedef struct packed {
    logic app_cpu;
    logic net_cpu;
    logic flash_if;
    logic periph_fast;
    logic usb;
    logic periph_mid;
    logic periph_slow;
    logic audio;
  } fcrc_gate_s;

  typedef struct packed {
    fcrc_ch_s    main;
    fcrc_ch_s    qspi;
    fcrc_ch_s    audio;
    fcrc_tri_s   ev;
    logic        main_sel;
    logic        qspi_sel;
    fcrc_tri_s   alw;
    logic [15:0] xo_cnt;
    logic [31:0] irq_en;
    logic        dph_wr;
    logic [11:0] dph_addr;
    logic [31:0] rdata;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
  } fcrc_state_s;

endpackage : fcrc_pkg

// *** design/fcrc_top.sv ***
/*
 * Fast clock request controller of one core: register slave, three
 * clock channels (main, flash interface, audio) and clock gate enables.
 * Assumes a shared power and clock subsystem that answers each request
 * with an asynchronous ready level and performs the actual switching.
 */
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
// What this block does
// - Any core request is forwarded while the system is on; gates open once the clock runs.
// - Request drops when core requests cease; subsystem stops only when all idle.
// - Main or flash request without explicit start uses internal oscillator, stopping when requests end; audio always uses the crystal.
// - Fast clocks reach the core only while the system is on.
// - Main source selection is latched only by the main start task.
// - Main started event waits for selected oscillator running and stable.
// - Flash interface source selection is latched only by its start task.
// - Flash interface started event waits for selected oscillator stable.
// - Audio start runs the crystal; audio started event when stable.
// - Retriggered start before its event yields one event for the last trigger.
// - Start after a raised event produces a fresh event.
// - Switch to crystal waits the programmed crystal startup count.
// - Crystal requested per channel; all clocks of one channel share its source.
// - Source stops only when stopped explicitly and no automatic requests remain, or when the system is off.
// - Stop only needed after start; repeated starts without stop are accepted.
// - Source changes are glitch free on the distributed clocks.
// - Core clocks of 128, 64, 192, 48, 32 and 16 MHz are provided.
// - Audio clock runs near 11.289 or 12.288 MHz, tunable.
// - Sources are internal 192/128/64 MHz oscillator and 32 MHz crystal.
// - Interrupt enable, set and clear share storage with the power block.
// - A source may be kept running ahead of requests, costing power.
`timescale 1ns/1ns

module fcrc_top (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                sys_on,
  input  wire fcrc_pkg::fcrc_tri_s auto_req,
  input  wire fcrc_pkg::fcrc_tri_s src_ready,
  output fcrc_pkg::fcrc_sub_s      sub_req,
  output fcrc_pkg::fcrc_gate_s     gates,
  output logic      [31:0]         irq_enable
);

  // ==========================================================
  // State
  fcrc_pkg::fcrc_state_s s_reg;
  fcrc_pkg::fcrc_state_s s_next;

  // Synchronised subsystem levels
  logic      sys_on_s;
  logic      rdy_main;
  logic      rdy_qspi;
  logic      rdy_audio;

  // Bus decode and task strobes
  logic      aph_valid;
  logic      wr_ok;
  logic      t_main_start;
  logic      t_main_stop;
  logic      t_qspi_start;
  logic      t_qspi_stop;
  logic      t_audio_start;
  logic      t_audio_stop;
  fcrc_pkg::fcrc_tri_s ev_clr;

  // ==========================================================
  // Channel step: one clock channel from request to running clock
  function automatic fcrc_pkg::fcrc_ch_s ch_step(
    input fcrc_pkg::fcrc_ch_s c,
    input logic               start,
    input logic               stop,
    input logic               autoreq,
    input logic               sel_cfg,
    input logic               alw_cfg,
    input logic               ready,
    input logic               on,
    input logic [15:0]        xo_cnt,
    input logic               force_xo
  );
    fcrc_pkg::fcrc_ch_s n;
    logic               req;
    logic               want;
    logic [15:0]        load;
    n     = c;
    n.evt = 1'b0;
    if (start) begin
      n.expl = 1'b1;
      n.pend = 1'b1;
      n.sel  = sel_cfg;
      n.alw  = alw_cfg;
    end else if (stop) begin
      n.expl = 1'b0;
      n.alw  = 1'b0;
      n.pend = 1'b0;
    end
    req  = on & (n.expl | n.alw | autoreq);
    want = force_xo ? fcrc_pkg::SRC_XO : (n.expl ? n.sel : fcrc_pkg::SRC_INT);
    load = (want == fcrc_pkg::SRC_XO) ? xo_cnt : 16'h0000;
    unique case (c.st)
      fcrc_pkg::CH_IDLE: begin
        if (req) begin
          n.act = want;
          n.cnt = load;
          n.st  = fcrc_pkg::CH_WAIT;
        end
      end
      fcrc_pkg::CH_WAIT: begin
        if (!req) begin
          n.st = fcrc_pkg::CH_IDLE;
        end else if (want != c.act) begin
          n.st = fcrc_pkg::CH_SWITCH;
        end else if (ready) begin
          if (c.cnt != 16'h0000) begin
            n.cnt = c.cnt - 16'h0001;
          end else begin
            n.st = fcrc_pkg::CH_RUN;
            if (n.pend) begin
              n.evt  = 1'b1;
              n.pend = 1'b0;
            end
          end
        end
      end
      fcrc_pkg::CH_RUN: begin
        if (!req) begin
          n.st = fcrc_pkg::CH_IDLE;
        end else if (want != c.act) begin
          n.st = fcrc_pkg::CH_SWITCH;
        end else if (n.pend) begin
          n.evt  = 1'b1;
          n.pend = 1'b0;
        end
      end
      fcrc_pkg::CH_SWITCH: begin
        // Ready of the old source is still in the synchroniser: wait for it to fall
        n.act = want;
        n.cnt = load;
        if (!req) begin
          n.st = fcrc_pkg::CH_IDLE;
        end else if (!ready) begin
          n.st = fcrc_pkg::CH_WAIT;
        end
      end
    endcase
    return n;
  endfunction : ch_step

  // ==========================================================
  // Register read multiplexer
  function automatic logic [31:0] rd_mux(
    input fcrc_pkg::fcrc_state_s s,
    input logic [11:0]           a
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      fcrc_pkg::OFS_EV_MAIN:   d[0] = s.ev.main;
      fcrc_pkg::OFS_EV_QSPI:   d[0] = s.ev.qspi;
      fcrc_pkg::OFS_EV_AUDIO:  d[0] = s.ev.audio;
      fcrc_pkg::OFS_IRQ_EN,
      fcrc_pkg::OFS_IRQ_EN_SET,
      fcrc_pkg::OFS_IRQ_EN_CLR: d = s.irq_en;
      fcrc_pkg::OFS_STATUS: begin
        d[fcrc_pkg::STAT_RUN_POS +: 3] = {s.main.st == fcrc_pkg::CH_RUN,
                                          s.qspi.st == fcrc_pkg::CH_RUN,
                                          s.audio.st == fcrc_pkg::CH_RUN};
        d[fcrc_pkg::STAT_SRC_POS +: 3] = {s.main.act, s.qspi.act, s.audio.act};
        d[fcrc_pkg::STAT_EXPL_POS +: 3] = {s.main.expl, s.qspi.expl,
                                           s.audio.expl};
      end
      fcrc_pkg::OFS_MAIN_SRC:  d[0] = s.main_sel;
      fcrc_pkg::OFS_MAIN_ALW:  d[0] = s.alw.main;
      fcrc_pkg::OFS_QSPI_SRC:  d[0] = s.qspi_sel;
      fcrc_pkg::OFS_QSPI_ALW:  d[0] = s.alw.qspi;
      fcrc_pkg::OFS_AUDIO_ALW: d[0] = s.alw.audio;
      fcrc_pkg::OFS_XO_CNT:    d[15:0] = s.xo_cnt;
      default:                 d = 32'h0000_0000;
    endcase
    return d;
  endfunction : rd_mux

  // ==========================================================
  // Bus decode
  // Zero wait states; every response is OKAY, unmapped reads give zero
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata;
  assign aph_valid = hsel & htrans[1] & hready;

  // Only whole-word writes reach the registers
  assign wr_ok = s_reg.dph_wr;

  // Task strobes in the write data phase, bit 0 set triggers
  assign t_main_start  = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_MAIN_START) & hwdata[0];
  assign t_main_stop   = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_MAIN_STOP) & hwdata[0];
  assign t_qspi_start  = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_QSPI_START) & hwdata[0];
  assign t_qspi_stop   = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_QSPI_STOP) & hwdata[0];
  assign t_audio_start = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_AUDIO_START) & hwdata[0];
  assign t_audio_stop  = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_AUDIO_STOP) & hwdata[0];

  // Writing zero to an event register clears it
  assign ev_clr.main  = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_EV_MAIN) & ~hwdata[0];
  assign ev_clr.qspi  = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_EV_QSPI) & ~hwdata[0];
  assign ev_clr.audio = wr_ok & (s_reg.dph_addr == fcrc_pkg::OFS_EV_AUDIO) & ~hwdata[0];

  // Second synchroniser stage only; the first stage is never read here
  assign sys_on_s  = s_reg.sync2[3];
  assign rdy_main  = s_reg.sync2[2];
  assign rdy_qspi  = s_reg.sync2[1];
  assign rdy_audio = s_reg.sync2[0];

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;

    // Subsystem levels are asynchronous to clk
    s_next.sync1 = {sys_on, src_ready.main, src_ready.qspi, src_ready.audio};
    s_next.sync2 = s_reg.sync1;

    // Address phase capture and registered read data
    s_next.dph_wr   = aph_valid & hwrite & (hsize == 3'b010);
    s_next.dph_addr = {haddr[11:2], 2'b00};
    if (aph_valid & ~hwrite) begin
      s_next.rdata = rd_mux(s_reg, {haddr[11:2], 2'b00});
    end

    // Configuration writes; source and always-run settings act only at a start task, interrupt enables at once
    if (wr_ok) begin
      unique case (s_reg.dph_addr)
        fcrc_pkg::OFS_MAIN_SRC:   s_next.main_sel  = hwdata[0];
        fcrc_pkg::OFS_MAIN_ALW:   s_next.alw.main  = hwdata[0];
        fcrc_pkg::OFS_QSPI_SRC:   s_next.qspi_sel  = hwdata[0];
        fcrc_pkg::OFS_QSPI_ALW:   s_next.alw.qspi  = hwdata[0];
        fcrc_pkg::OFS_AUDIO_ALW:  s_next.alw.audio = hwdata[0];
        fcrc_pkg::OFS_XO_CNT:     s_next.xo_cnt    = hwdata[15:0];
        fcrc_pkg::OFS_IRQ_EN:     s_next.irq_en    = hwdata;
        fcrc_pkg::OFS_IRQ_EN_SET: s_next.irq_en    = s_reg.irq_en | hwdata;
        fcrc_pkg::OFS_IRQ_EN_CLR: s_next.irq_en    = s_reg.irq_en & ~hwdata;
        default:                  s_next.irq_en    = s_reg.irq_en;
      endcase
    end

    s_next.main = ch_step(s_reg.main, t_main_start, t_main_stop, auto_req.main,
                          s_reg.main_sel, s_reg.alw.main, rdy_main, sys_on_s,
                          s_reg.xo_cnt, 1'b0);
    s_next.qspi = ch_step(s_reg.qspi, t_qspi_start, t_qspi_stop, auto_req.qspi,
                          s_reg.qspi_sel, s_reg.alw.qspi, rdy_qspi, sys_on_s,
                          s_reg.xo_cnt, 1'b0);
    s_next.audio = ch_step(s_reg.audio, t_audio_start, t_audio_stop,
                           auto_req.audio, fcrc_pkg::SRC_XO, s_reg.alw.audio,
                           rdy_audio, sys_on_s, s_reg.xo_cnt, 1'b1);

    s_next.ev.main  = (s_reg.ev.main & ~ev_clr.main) | s_reg.main.evt;
    s_next.ev.qspi  = (s_reg.ev.qspi & ~ev_clr.qspi) | s_reg.qspi.evt;
    s_next.ev.audio = (s_reg.ev.audio & ~ev_clr.audio) | s_reg.audio.evt;
  end

  // ==========================================================
  // State register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg        <= '0;
      s_reg.xo_cnt <= fcrc_pkg::XO_CNT_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Requests to the shared subsystem
  // Level falls only with no explicit, always-run or automatic need, or when the system is off
  // Always-run keeps the request up only while the system is on
  assign sub_req.req.main   = s_reg.main.st != fcrc_pkg::CH_IDLE;
  assign sub_req.req.qspi   = s_reg.qspi.st != fcrc_pkg::CH_IDLE;
  assign sub_req.req.audio  = s_reg.audio.st != fcrc_pkg::CH_IDLE;
  assign sub_req.expl.main  = s_reg.main.expl;
  assign sub_req.expl.qspi  = s_reg.qspi.expl;
  assign sub_req.expl.audio = s_reg.audio.expl;
  assign sub_req.src.main   = s_reg.main.act;
  assign sub_req.src.qspi   = s_reg.qspi.act;
  assign sub_req.src.audio  = s_reg.audio.act;

  // ==========================================================
  // Clock gate enables
  // Every clock of a channel shares its source
  // Main feeds CPU and peripheral clocks, flash channel the USB one
  // Gates shut two cycles after sys_on falls, once the low level has passed the synchroniser
  always_comb begin
    gates             = '0;
    gates.app_cpu     = sys_on_s & (s_reg.main.st == fcrc_pkg::CH_RUN);
    gates.net_cpu     = gates.app_cpu;
    gates.periph_fast = gates.app_cpu;
    gates.periph_mid  = gates.app_cpu;
    gates.periph_slow = gates.app_cpu;
    gates.flash_if    = sys_on_s & (s_reg.qspi.st == fcrc_pkg::CH_RUN);
    gates.usb         = gates.flash_if;
    // Audio clock tuned elsewhere, gated here
    gates.audio       = sys_on_s & (s_reg.audio.st == fcrc_pkg::CH_RUN);
  end

  assign irq_enable = s_reg.irq_en;

endmodule : fcrc_top

// *** verif/fcrc_subsys_model.sv ***
/*
 * Behavioural shared power and clock subsystem with its oscillators.
 * Assumes one requesting core; ready is a level the design synchronises.
 */
`timescale 1ns/1ns

module fcrc_subsys_model (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                slow,
  input  wire fcrc_pkg::fcrc_sub_s sub_req,
  output fcrc_pkg::fcrc_tri_s      src_ready
);
  logic [7:0] cnt_reg [3];
  logic [2:0] src_reg;
  logic [2:0] rdy;
  logic [7:0] lat;

  // Slow mode mimics a crystal that takes long to settle
  assign lat = slow ? 8'h14 : 8'h03;

  // ==========================================================
  // Oscillator start-up per channel
  // run only when requested
  always_ff @(posedge clk) begin
    src_reg <= sub_req.src;
    for (int i = 0; i < 3; i++) begin
      if (!nrst || !sub_req.req[i] || sub_req.src[i] != src_reg[i]) begin
        cnt_reg[i] <= 8'h00;
      end else if (cnt_reg[i] != 8'hFF) begin
        cnt_reg[i] <= cnt_reg[i] + 8'h01;
      end
    end
  end

  // Ready falls as soon as the request goes, never holds a stale level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rdy[i] = (cnt_reg[i] >= lat) && sub_req.req[i] && (sub_req.src[i] == src_reg[i]);
    end
  end
  assign src_ready = fcrc_pkg::fcrc_tri_s'(rdy);
endmodule : fcrc_subsys_model

// *** verif/fcrc_top_sva.sv ***
/*
 * Port checker for fcrc_top, bound into every instance of it.
 * Assumes one clk domain with synchronous active-low nrst.
 */
`timescale 1ns/1ns

module fcrc_top_sva (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                ce,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic                sys_on,
  input wire fcrc_pkg::fcrc_tri_s auto_req,
  input wire fcrc_pkg::fcrc_tri_s src_ready,
  input wire fcrc_pkg::fcrc_sub_s sub_req,
  input wire fcrc_pkg::fcrc_gate_s gates
);
  logic       ap_wr;
  logic [1:0] ap_reg;
  logic [3:0] age_m_reg;
  logic [3:0] age_q_reg;

  // ==========================================================
  // Helpers: cycles since the last start or stop task of the main and flash channels
  assign ap_wr = hsel && htrans[1] && hready && ce && hwrite && hsize == 3'h2;

  // Stop counts too, since it may hand the channel back to the internal source
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ap_reg    <= 2'h0;
      age_m_reg <= 4'hF;
      age_q_reg <= 4'hF;
    end else begin
      ap_reg[1] <= ap_wr && haddr[11:3] == fcrc_pkg::OFS_MAIN_START[11:3];
      ap_reg[0] <= ap_wr && haddr[11:3] == fcrc_pkg::OFS_QSPI_START[11:3];
      age_m_reg <= (ap_reg[1] && hwdata[0]) ? 4'h0 : age_m_reg + {3'h0, age_m_reg != 4'hF};
      age_q_reg <= (ap_reg[0] && hwdata[0]) ? 4'h0 : age_q_reg + {3'h0, age_q_reg != 4'hF};
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_main_task;
    age_m_reg < 4'h8;
  endsequence

  sequence s_qspi_task;
    age_q_reg < 4'h8;
  endsequence

  AST_REQ_FWD: assert property ((auto_req.main && sys_on)[*6] |-> sub_req.req.main)
    else $error("automatic request not forwarded");
  AST_OFF_GATES: assert property ((!sys_on)[*5] |-> gates == '0 && sub_req.req == '0)
    else $error("clock delivered while system off");
  AST_MAIN_READY: assert property ($rose(gates.app_cpu) |-> $past(src_ready.main, 2))
    else $error("main gate opened before source ready");
  AST_QSPI_READY: assert property ($rose(gates.flash_if) |-> $past(src_ready.qspi, 2))
    else $error("flash gate opened before source ready");
  AST_AUDIO_XO: assert property ($rose(gates.audio) |-> $past(src_ready.audio, 2) && sub_req.src.audio)
    else $error("audio gate opened without running crystal");
  AST_MAIN_SRC: assert property ($rose(sub_req.src.main) |-> s_main_task)
    else $error("main source changed without a task");
  AST_QSPI_SRC: assert property ($rose(sub_req.src.qspi) |-> s_qspi_task)
    else $error("flash source changed without a task");
  AST_EXPL_CLR: assert property ($fell(sub_req.expl.main) |-> s_main_task)
    else $error("explicit flag dropped without stop");
  AST_SWITCH: assert property ($changed(sub_req.src.main) |-> !gates.app_cpu)
    else $error("gate kept open across source change");
endmodule : fcrc_top_sva

bind fcrc_top fcrc_top_sva u_sva (
  .clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .sys_on(sys_on),
  .auto_req(auto_req), .src_ready(src_ready), .sub_req(sub_req), .gates(gates)
);

// *** verif/tb_fcrc_top.sv ***
/*
 * Self-checking bench for fcrc_top with the subsystem model at its far side.
 * Assumes zero-wait AHB-Lite slave; the bench is the only bus master.
 */
`timescale 1ns/1ns

module tb_fcrc_top;
  logic                 clk;
  logic                 nrst;
  logic                 ce;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic                 sys_on;
  logic                 slow;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic [31:0]          irq_enable;
  fcrc_pkg::fcrc_tri_s  auto_req;
  fcrc_pkg::fcrc_tri_s  src_ready;
  fcrc_pkg::fcrc_sub_s  sub_req;
  fcrc_pkg::fcrc_gate_s gates;
  int                   n_errors;
  int                   tests_run;
  logic [31:0]          rd;
  int                   n;

  fcrc_top dut (
    .clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sys_on(sys_on),
    .auto_req(auto_req), .src_ready(src_ready), .sub_req(sub_req), .gates(gates),
    .irq_enable(irq_enable)
  );

  fcrc_subsys_model u_model (
    .clk(clk), .nrst(nrst), .slow(slow), .sub_req(sub_req), .src_ready(src_ready)
  );

  // ==========================================================
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Address phase held until hready, then data phase until hready again
  task automatic ahb(input logic [11:0] a, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    haddr  <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (!hreadyout);
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(a, 1'b1, d, q);
  endtask : wr

  // Outputs are looked at mid-cycle, where they are settled
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    settle(1);
    check(sub_req, '0, "request after reset");
    check(gates, '0, "gates after reset");
    check(irq_enable, 32'h0000_0000, "irq after reset");
    ahb(fcrc_pkg::OFS_XO_CNT, 1'b0, 32'h0000_0000, rd);
    check(rd, {16'h0000, fcrc_pkg::XO_CNT_RST}, "count reset");
  endtask : do_reset

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    wr(fcrc_pkg::OFS_IRQ_EN_SET, 32'h0000_0005);
    wr(fcrc_pkg::OFS_IRQ_EN_CLR, 32'h0000_0001);
    ahb(fcrc_pkg::OFS_IRQ_EN, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0004, "irq enable");
    check(irq_enable, 32'h0000_0004, "irq port");
    ahb(12'h7F0, 1'b0, 32'h0000_0000, rd);
    check({rd, hresp}, 33'h0, "unmapped");
    $display("test regs done");
  endtask : t_regs

  task automatic t_auto;
    @(posedge clk);
    sys_on <= 1'b1;
    auto_req.main <= 1'b1;
    settle(20);
    check(gates.app_cpu, 1'b1, "auto gate");
    check(sub_req.src.main, fcrc_pkg::SRC_INT, "auto source");
    check(gates.net_cpu & gates.periph_slow, 1'b1, "core clocks");
    @(posedge clk);
    sys_on <= 1'b0;
    settle(6);
    check({gates, sub_req.req}, '0, "off state");
    @(posedge clk);
    sys_on <= 1'b1;
    settle(20);
    check(gates.app_cpu, 1'b1, "back on");
    @(posedge clk);
    auto_req.main <= 1'b0;
    settle(4);
    check({sub_req.req.main, gates.app_cpu}, 2'b00, "withdraw");
    $display("test auto done");
  endtask : t_auto

  task automatic t_main;
    @(posedge clk);
    auto_req.main <= 1'b1;
    wr(fcrc_pkg::OFS_XO_CNT, 32'h0000_0008);
    wr(fcrc_pkg::OFS_MAIN_SRC, 32'h0000_0001);
    settle(4);
    check(sub_req.src.main, fcrc_pkg::SRC_INT, "source before start");
    wr(fcrc_pkg::OFS_MAIN_START, 32'h0000_0001);
    wr(fcrc_pkg::OFS_MAIN_START, 32'h0000_0001);
    check(sub_req.expl.main, 1'b1, "explicit flag");
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!gates.app_cpu && n < 300);
    check(n > 8 && n < 300, 1'b1, "crystal count");
    settle(2);
    check(sub_req.src.main, fcrc_pkg::SRC_XO, "crystal source");
    ahb(fcrc_pkg::OFS_EV_MAIN, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0001, "main started");
    wr(fcrc_pkg::OFS_EV_MAIN, 32'h0000_0000);
    settle(10);
    ahb(fcrc_pkg::OFS_EV_MAIN, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "one event");
    wr(fcrc_pkg::OFS_MAIN_START, 32'h0000_0001);
    settle(4);
    ahb(fcrc_pkg::OFS_EV_MAIN, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0001, "fresh event");
    wr(fcrc_pkg::OFS_MAIN_STOP, 32'h0000_0001);
    settle(2);
    check({sub_req.expl.main, sub_req.req.main}, 2'b01, "stop with auto");
    @(posedge clk);
    auto_req.main <= 1'b0;
    settle(4);
    check(sub_req.req.main, 1'b0, "all stopped");
    $display("test main done");
  endtask : t_main

  task automatic t_other;
    @(posedge clk);
    slow <= 1'b1;
    wr(fcrc_pkg::OFS_QSPI_SRC, 32'h0000_0001);
    wr(fcrc_pkg::OFS_QSPI_START, 32'h0000_0001);
    wr(fcrc_pkg::OFS_AUDIO_START, 32'h0000_0001);
    settle(80);
    check({gates.flash_if, gates.usb, sub_req.src.qspi}, 3'b111, "flash clock");
    check({gates.audio, sub_req.src.audio}, 2'b11, "audio crystal");
    ahb(fcrc_pkg::OFS_EV_QSPI, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0001, "flash started");
    ahb(fcrc_pkg::OFS_EV_AUDIO, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0001, "audio started");
    wr(fcrc_pkg::OFS_QSPI_STOP, 32'h0000_0001);
    wr(fcrc_pkg::OFS_AUDIO_STOP, 32'h0000_0001);
    settle(4);
    check(sub_req.req, '0, "sources stopped");
    $display("test other done");
  endtask : t_other

  task automatic t_freeze;
    @(posedge clk);
    auto_req.main <= 1'b1;
    settle(20);
    @(posedge clk);
    ce <= 1'b0;
    auto_req.main <= 1'b0;
    settle(5);
    check(sub_req.req.main, 1'b1, "frozen");
    @(posedge clk);
    ce <= 1'b1;
    settle(3);
    check(sub_req.req.main, 1'b0, "thawed");
    $display("test freeze done");
  endtask : t_freeze

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    n_errors  = 0;
    tests_run = 0;
    nrst     <= 1'b0;
    ce       <= 1'b1;
    hsel     <= 1'b1;
    haddr    <= 32'h0000_0000;
    htrans   <= 2'b00;
    hwrite   <= 1'b0;
    hsize    <= 3'h2;
    hwdata   <= 32'h0000_0000;
    sys_on   <= 1'b0;
    slow     <= 1'b0;
    auto_req <= '0;
    do_reset();
    t_regs();
    t_auto();
    t_main();
    t_other();
    t_freeze();
    // Reset again after the last scenario
    do_reset();
    wrap_up();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("MISMATCH at %0t: timeout", $time);
    wrap_up();
  end
endmodule : tb_fcrc_top
